// [core/tpif_core.sv]
// Behaviour
// - compare-A flag sets on match; clears on vector or one cycle after write-one.
// - compare-B flag sets on match; clears on vector or one cycle after write-one.
// - fast overflow flag sets on overflow; vector or delayed write-one clears it.
// - basic overflow flag sets on overflow; vector or immediate write-one clears it.
// - timer request needs global enable, its enable bit and its flag together.
// - unused timer flag bits always read zero.
// - external interrupt fires even when its pin is driven as output.
// - external sense selects falling, rising, any change or low level.
// - wake needs two watchdog-tick samples at the required level.
// - pin-change fires on port B and port A pins 3, 6, 7 if unmasked.
// - upper enable covers PB7..4 and PA7,6,3; lower covers PB3..0.
// - disabled group cannot set the pin-change flag at all.
// - a pin with active alternate function produces no pin-change event.
// - pin-change fires even when the pin is an output.
// - one pin event may raise pin-change and external requests together.
// - mask PA3 if reference select is 1; PA6, PA7 if comparator disable is 0.
// - mask PB0 in two-wire or three-wire serial mode or inverted compare output.
// - fuse value 0 means programmed, 1 unprogrammed.
// - one shared pin-change flag; vector or write-one clears it.
// - external flag held clear in low-level mode; request follows the pin.
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tpif_params.svh"
module tpif_core
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // CPU core side
    input wire logic global_irq_en,
    input wire logic vec_ack,
    input wire logic [2:0] vec_num,
    output logic [6:1] irq_req,
    // Timer events, same clock
    input wire tpif_pkg::tpif_timer_evt_t timer_evt,
    // Pins and wake sampling
    input wire logic [7:0] port_a_pin,
    input wire logic [7:0] port_b_pin,
    input wire logic wdt_tick,
    input wire tpif_pkg::tpif_fuse_t fuses,
    output logic wake_req
);
    // ****************************************************************
    // Register bus
    // ****************************************************************
    tpif_pkg::tpif_bus_state_t bus_state, next_bus_state;
    logic [11:0] wr_addr, next_wr_addr;
    logic [7:0] timer_mask, next_timer_mask;
    logic [7:0] gen_mask, next_gen_mask;
    logic [1:0] mcu_ctrl, next_mcu_ctrl;
    tpif_pkg::tpif_alt_t alt_ctrl, next_alt_ctrl;
    logic [31:0] rdata, next_rdata;
    logic wr_now;
    logic [7:0] wbyte;
    logic [7:0] timer_flags, gen_flags;
    logic [2:0] fast_clr_pend, next_fast_clr_pend;
    logic basic_clr;
    logic ext_clr;
    logic pc_clr;
    logic [7:0] status_word;

    // Decode an address to a register match
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata;
    assign wr_now = (bus_state == tpif_pkg::TPIF_BUS_DATA);
    assign wbyte = hwdata[7:0];

    // Address phase capture, writes land in the data phase
    always_comb
    begin
        next_bus_state = tpif_pkg::TPIF_BUS_IDLE;
        next_wr_addr = wr_addr;
        next_rdata = rdata;
        next_timer_mask = timer_mask;
        next_gen_mask = gen_mask;
        next_mcu_ctrl = mcu_ctrl;
        next_alt_ctrl = alt_ctrl;
        case (bus_state)
            tpif_pkg::TPIF_BUS_IDLE: ;
            tpif_pkg::TPIF_BUS_DATA:
            begin
                if (hit(wr_addr, `TPIF_OFS_TIMER_MASK))
                    next_timer_mask = wbyte & `TPIF_TIMER_FLAG_MASK;
                if (hit(wr_addr, `TPIF_OFS_GEN_MASK))
                    next_gen_mask = wbyte & `TPIF_GEN_MASK_MASK;
                if (hit(wr_addr, `TPIF_OFS_MCU_CTRL))
                    next_mcu_ctrl = wbyte[1:0];
                if (hit(wr_addr, `TPIF_OFS_ALT_CTRL))
                    next_alt_ctrl = hwdata[11:0];
            end
            default: ;
        endcase
        if (hsel && hready && htrans[1])
        begin
            if (hwrite)
            begin
                next_bus_state = tpif_pkg::TPIF_BUS_DATA;
                next_wr_addr = haddr;
            end
            else
            begin
                // Unmapped reads return zero
                next_rdata = 32'h0000_0000;
                if (hit(haddr, `TPIF_OFS_TIMER_FLAGS))
                    next_rdata[7:0] = timer_flags;
                if (hit(haddr, `TPIF_OFS_TIMER_MASK))
                    next_rdata[7:0] = timer_mask;
                if (hit(haddr, `TPIF_OFS_GEN_MASK))
                    next_rdata[7:0] = gen_mask;
                if (hit(haddr, `TPIF_OFS_GEN_FLAGS))
                    next_rdata[7:0] = gen_flags;
                if (hit(haddr, `TPIF_OFS_MCU_CTRL))
                    next_rdata[1:0] = mcu_ctrl;
                if (hit(haddr, `TPIF_OFS_ALT_CTRL))
                    next_rdata[11:0] = alt_ctrl;
                if (hit(haddr, `TPIF_OFS_STATUS))
                    next_rdata[7:0] = status_word;
            end
        end
    end

    // Bus registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bus_state <= tpif_pkg::TPIF_BUS_IDLE;
            wr_addr <= 12'h000;
            rdata <= 32'h0000_0000;
            timer_mask <= `TPIF_RESET_BYTE;
            gen_mask <= `TPIF_RESET_BYTE;
            mcu_ctrl <= 2'h0;
            alt_ctrl <= 12'h000;
        end
        else
        begin
            bus_state <= next_bus_state;
            wr_addr <= next_wr_addr;
            rdata <= next_rdata;
            timer_mask <= next_timer_mask;
            gen_mask <= next_gen_mask;
            mcu_ctrl <= next_mcu_ctrl;
            alt_ctrl <= next_alt_ctrl;
        end
    end

    // ****************************************************************
    // Timer flags
    // ****************************************************************
    logic cmp_a_flag, cmp_b_flag, fast_ovf_flag, basic_ovf_flag;
    logic next_cmp_a_flag, next_cmp_b_flag, next_fast_ovf_flag, next_basic_ovf_flag;
    logic tf_write;

    assign tf_write = wr_now && hit(wr_addr, `TPIF_OFS_TIMER_FLAGS);
    assign basic_clr = tf_write && wbyte[`TPIF_BIT_BASIC_OVF];
    assign timer_flags = {1'b0, cmp_a_flag, cmp_b_flag, 2'b00,
        fast_ovf_flag, basic_ovf_flag, 1'b0};

    // Fast flag write-one clears pass a sync stage; set wins over clear
    always_comb
    begin
        next_fast_clr_pend = 3'h0;
        if (tf_write)
            next_fast_clr_pend = {wbyte[`TPIF_BIT_CMP_A], wbyte[`TPIF_BIT_CMP_B],
                wbyte[`TPIF_BIT_FAST_OVF]};
        next_cmp_a_flag = timer_evt.cmp_a ||
            (cmp_a_flag && !fast_clr_pend[2] &&
            !(vec_ack && vec_num == `TPIF_VEC_CMP_A));
        next_cmp_b_flag = timer_evt.cmp_b ||
            (cmp_b_flag && !fast_clr_pend[1] &&
            !(vec_ack && vec_num == `TPIF_VEC_CMP_B));
        next_fast_ovf_flag = timer_evt.fast_ovf ||
            (fast_ovf_flag && !fast_clr_pend[0] &&
            !(vec_ack && vec_num == `TPIF_VEC_FAST_OVF));
        next_basic_ovf_flag = timer_evt.basic_ovf ||
            (basic_ovf_flag && !basic_clr &&
            !(vec_ack && vec_num == `TPIF_VEC_BASIC_OVF));
    end

    // Timer flag registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fast_clr_pend <= 3'h0;
            cmp_a_flag <= 1'b0;
            cmp_b_flag <= 1'b0;
            fast_ovf_flag <= 1'b0;
            basic_ovf_flag <= 1'b0;
        end
        else
        begin
            fast_clr_pend <= next_fast_clr_pend;
            cmp_a_flag <= next_cmp_a_flag;
            cmp_b_flag <= next_cmp_b_flag;
            fast_ovf_flag <= next_fast_ovf_flag;
            basic_ovf_flag <= next_basic_ovf_flag;
        end
    end

    // ****************************************************************
    // Pin sampling and masking
    // ****************************************************************
    // Pin vector: {PA7, PA6, PA3, PB7..PB0}
    localparam int NPIN = 11;
    logic [NPIN-1:0] pin_raw, sync1, sync2, prev_pin, pin_mask, pin_changed;
    logic [NPIN-1:0] group_en;
    logic ext_pin;

    assign pin_raw = {port_a_pin[7], port_a_pin[6], port_a_pin[3], port_b_pin};
    assign ext_pin = sync2[6]; // PB6 carries the external pin

    // Two-stage synchronisers and previous sample per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    prev_pin[gi] <= 1'b0;
                end
                else
                begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    prev_pin[gi] <= sync2[gi];
                end
            end
        end
    endgenerate

    // Alternate-function masks per pin
    always_comb
    begin
        pin_mask = '0;
        pin_mask[8] = alt_ctrl.ref_select_bit;
        pin_mask[9] = !alt_ctrl.comparator_disable;
        pin_mask[10] = !alt_ctrl.comparator_disable;
        pin_mask[0] = alt_ctrl.serial_wire_mode_hi ||
            (!alt_ctrl.serial_wire_mode_hi && alt_ctrl.serial_wire_mode_lo) ||
            (!alt_ctrl.cmp_a_out_mode_hi && alt_ctrl.cmp_a_out_mode_lo &&
            alt_ctrl.pwm_a_enable);
        pin_mask[1] = (!alt_ctrl.serial_wire_mode_hi && alt_ctrl.serial_wire_mode_lo) ||
            alt_ctrl.cmp_a_out_mode_hi || alt_ctrl.cmp_a_out_mode_lo;
        pin_mask[2] = alt_ctrl.serial_wire_mode_hi ||
            (!alt_ctrl.serial_wire_mode_hi && alt_ctrl.serial_wire_mode_lo) ||
            (!alt_ctrl.cmp_b_out_mode_hi && alt_ctrl.cmp_b_out_mode_lo &&
            alt_ctrl.pwm_b_enable);
        pin_mask[3] = alt_ctrl.cmp_b_out_mode_hi || alt_ctrl.cmp_b_out_mode_lo;
        // Fuse 0 is programmed
        pin_mask[4] = (fuses.pll_clock_fuse && fuses.clock_source_fuses == 4'h0) ||
            (fuses.pll_clock_fuse && fuses.clock_source_fuses >= 4'h5);
        pin_mask[5] = fuses.pll_clock_fuse && fuses.clock_source_fuses >= 4'h9;
        pin_mask[6] = (gen_mask[`TPIF_BIT_EXT] && mcu_ctrl == 2'h0) ||
            (alt_ctrl.basic_clksel_b2 && alt_ctrl.basic_clksel_b1);
        pin_mask[7] = fuses.reset_pin_disable_fuse;
    end

    // Group enables: upper covers PA7,6,3 and PB7..4
    assign group_en = {{3{gen_mask[`TPIF_BIT_PC_UP]}}, {4{gen_mask[`TPIF_BIT_PC_UP]}},
        {4{gen_mask[`TPIF_BIT_PC_LO]}}};
    // Driven outputs still change at the pad: no direction gating
    assign pin_changed = (sync2 ^ prev_pin) & ~pin_mask & group_en;

    // ****************************************************************
    // External and pin-change flags
    // ****************************************************************
    logic ext_flag, next_ext_flag, pc_flag, next_pc_flag;
    logic ext_event, gf_write, low_mode;
    logic [1:0] wake_cnt, next_wake_cnt;

    assign low_mode = (mcu_ctrl == tpif_pkg::TPIF_SENSE_LOW);
    assign gf_write = wr_now && hit(wr_addr, `TPIF_OFS_GEN_FLAGS);
    assign ext_clr = (gf_write && wbyte[`TPIF_BIT_EXT]) ||
        (vec_ack && vec_num == `TPIF_VEC_EXT);
    assign pc_clr = (gf_write && wbyte[`TPIF_BIT_PC_FLAG]) ||
        (vec_ack && vec_num == `TPIF_VEC_PINCHG);
    assign gen_flags = {1'b0, ext_flag, pc_flag, 5'h00};
    assign status_word = {1'b0, ext_pin, 6'h00};

    // External pin edge select
    always_comb
    begin
        case (tpif_pkg::tpif_sense_t'(mcu_ctrl))
            tpif_pkg::TPIF_SENSE_ANY: ext_event = sync2[6] ^ prev_pin[6];
            tpif_pkg::TPIF_SENSE_FALL: ext_event = !sync2[6] && prev_pin[6];
            tpif_pkg::TPIF_SENSE_RISE: ext_event = sync2[6] && !prev_pin[6];
            default: ext_event = 1'b0;
        endcase
    end

    // Flag updates; set wins over clear, low mode holds the flag clear
    always_comb
    begin
        next_ext_flag = 1'b0;
        if (!low_mode)
            next_ext_flag = ext_event || (ext_flag && !ext_clr);
        next_pc_flag = (|pin_changed) || (pc_flag && !pc_clr);
        // Two watchdog samples in a row at the wake level wake the core
        next_wake_cnt = wake_cnt;
        if (wdt_tick)
        begin
            if ((low_mode && !ext_pin && gen_mask[`TPIF_BIT_EXT]) ||
                ((!low_mode) && (ext_flag || pc_flag)))
                next_wake_cnt = (wake_cnt == 2'h2) ? 2'h2 : wake_cnt + 2'h1;
            else
                next_wake_cnt = 2'h0;
        end
    end

    // Pin flag registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_flag <= 1'b0;
            pc_flag <= 1'b0;
            wake_cnt <= 2'h0;
        end
        else
        begin
            ext_flag <= next_ext_flag;
            pc_flag <= next_pc_flag;
            wake_cnt <= next_wake_cnt;
        end
    end

    assign wake_req = (wake_cnt == 2'h2);

    // ****************************************************************
    // Interrupt requests
    // ****************************************************************
    always_comb
    begin
        irq_req[1] = global_irq_en && gen_mask[`TPIF_BIT_EXT] &&
            (low_mode ? !ext_pin : ext_flag);
        irq_req[2] = global_irq_en && pc_flag &&
            (gen_mask[`TPIF_BIT_PC_UP] || gen_mask[`TPIF_BIT_PC_LO]);
        irq_req[3] = global_irq_en && timer_mask[`TPIF_BIT_CMP_A] && cmp_a_flag;
        irq_req[4] = global_irq_en && timer_mask[`TPIF_BIT_CMP_B] && cmp_b_flag;
        irq_req[5] = global_irq_en && timer_mask[`TPIF_BIT_FAST_OVF] && fast_ovf_flag;
        irq_req[6] = global_irq_en && timer_mask[`TPIF_BIT_BASIC_OVF] && basic_ovf_flag;
    end
endmodule // tpif_core
`default_nettype wire

// [core/tpif_params.svh]
`ifndef TPIF_PARAMS_SVH
`define TPIF_PARAMS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TPIF_OFS_TIMER_FLAGS 12'h000
`define TPIF_OFS_TIMER_MASK 12'h004
`define TPIF_OFS_GEN_MASK 12'h008
`define TPIF_OFS_GEN_FLAGS 12'h00c
`define TPIF_OFS_MCU_CTRL 12'h010
`define TPIF_OFS_ALT_CTRL 12'h014
`define TPIF_OFS_STATUS 12'h018
// ****************************************************************
// Field positions
// ****************************************************************
`define TPIF_BIT_CMP_A 6
`define TPIF_BIT_CMP_B 5
`define TPIF_BIT_FAST_OVF 2
`define TPIF_BIT_BASIC_OVF 1
`define TPIF_BIT_EXT 6
`define TPIF_BIT_PC_UP 5
`define TPIF_BIT_PC_LO 4
`define TPIF_BIT_PC_FLAG 5
`define TPIF_TIMER_FLAG_MASK 8'h66
`define TPIF_GEN_MASK_MASK 8'h70
`define TPIF_RESET_BYTE 8'h00
// Acknowledge vector numbers
`define TPIF_VEC_EXT 3'h1
`define TPIF_VEC_PINCHG 3'h2
`define TPIF_VEC_CMP_A 3'h3
`define TPIF_VEC_CMP_B 3'h4
`define TPIF_VEC_FAST_OVF 3'h5
`define TPIF_VEC_BASIC_OVF 3'h6
`endif

// [core/tpif_pkg.sv]
package tpif_pkg;
    // External interrupt sense mode
    typedef enum logic [1:0]
    {
        TPIF_SENSE_LOW = 2'h0,
        TPIF_SENSE_ANY = 2'h1,
        TPIF_SENSE_FALL = 2'h2,
        TPIF_SENSE_RISE = 2'h3
    } tpif_sense_t;
    // Timer event pulses
    typedef struct packed
    {
        logic cmp_a;
        logic cmp_b;
        logic fast_ovf;
        logic basic_ovf;
    } tpif_timer_evt_t;
    // Alternate functions that mask pin-change pins
    typedef struct packed
    {
        logic ref_select_bit;
        logic comparator_disable;
        logic serial_wire_mode_hi;
        logic serial_wire_mode_lo;
        logic cmp_a_out_mode_hi;
        logic cmp_a_out_mode_lo;
        logic cmp_b_out_mode_hi;
        logic cmp_b_out_mode_lo;
        logic pwm_a_enable;
        logic pwm_b_enable;
        logic basic_clksel_b2;
        logic basic_clksel_b1;
    } tpif_alt_t;
    // Fuse levels, 0 means programmed
    typedef struct packed
    {
        logic reset_pin_disable_fuse;
        logic pll_clock_fuse;
        logic [3:0] clock_source_fuses;
    } tpif_fuse_t;
    // Bus slave data-phase state
    typedef enum logic [1:0]
    {
        TPIF_BUS_IDLE = 2'b01,
        TPIF_BUS_DATA = 2'b10
    } tpif_bus_state_t;
endpackage

// [dv/tpif_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpif_params.svh"
module tpif_checker
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Core side and timer events
    input wire logic global_irq_en,
    input wire logic vec_ack,
    input wire logic [2:0] vec_num,
    input wire logic [6:1] irq_req,
    input wire tpif_pkg::tpif_timer_evt_t timer_evt
);
    logic take;
    logic on_flags;
    logic [3:0] dp;
    // Address phase taken, and whether it hits the timer flags
    assign take = hsel && hready && htrans[1];
    assign on_flags = haddr == `TPIF_OFS_TIMER_FLAGS;
    // Data phase marks: write, write a cycle back, flag write, flag read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dp <= 4'h0;
        else
            dp <= {take && hwrite, dp[3], take && hwrite && on_flags, take && !hwrite && on_flags};
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_cmp_a_vec;
        vec_ack && vec_num == `TPIF_VEC_CMP_A && !timer_evt.cmp_a |=> !irq_req[3];
    endproperty
    a_cmp_a_vec: assert property (p_cmp_a_vec) else $error("cmp a request after vector");
    property p_cmp_b_vec;
        vec_ack && vec_num == `TPIF_VEC_CMP_B && !timer_evt.cmp_b |=> !irq_req[4];
    endproperty
    a_cmp_b_vec: assert property (p_cmp_b_vec) else $error("cmp b request after vector");
    property p_fast_vec;
        vec_ack && vec_num == `TPIF_VEC_FAST_OVF && !timer_evt.fast_ovf |=> !irq_req[5];
    endproperty
    a_fast_vec: assert property (p_fast_vec) else $error("fast request after vector");
    property p_basic_wr;
        dp[1] && hwdata[`TPIF_BIT_BASIC_OVF] && !timer_evt.basic_ovf |=> !irq_req[6];
    endproperty
    a_basic_wr: assert property (p_basic_wr) else $error("basic flag clear late");
    property p_cmp_a_wr;
        dp[1] && hwdata[`TPIF_BIT_CMP_A] && irq_req[3] && !vec_ack
            && !timer_evt.cmp_a |=> irq_req[3] ##1 (!irq_req[3] || $past(timer_evt.cmp_a));
    endproperty
    a_cmp_a_wr: assert property (p_cmp_a_wr) else $error("cmp a clear not one cycle late");
    property p_global;
        !global_irq_en |-> irq_req[6:3] == 4'h0;
    endproperty
    a_global: assert property (p_global) else $error("request without global enable");
    property p_unused;
        dp[0] |-> (hrdata & ~{24'h0, `TPIF_TIMER_FLAG_MASK}) == 32'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused flag bits nonzero");
    property p_fast_hold;
        irq_req[5] && !vec_ack && !dp[3] && !dp[2] |=> irq_req[5] || !global_irq_en;
    endproperty
    a_fast_hold: assert property (p_fast_hold) else $error("fast request dropped alone");
endmodule // tpif_checker
bind tpif_core tpif_checker u_tpif_checker
(
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .global_irq_en, .vec_ack, .vec_num, .irq_req, .timer_evt
);
`default_nettype wire

// [dv/tpif_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tpif_cpu_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic serve_en,
    input wire logic [3:0] extra_wait,
    // Requests and acknowledge
    input wire logic global_irq_en,
    input wire logic [6:1] irq_req,
    output logic vec_ack,
    output logic [2:0] vec_num
);
    logic [2:0] pick;
    logic [4:0] wait_cnt;
    // Lowest pending vector number wins
    always_comb
    begin
        pick = 3'h0;
        for (int i = 6; i >= 1; i--)
            if (irq_req[i])
                pick = 3'(i);
    end
    // Wait, then a one-cycle acknowledge; vector lines wander when idle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_cnt <= 5'h00;
            vec_ack <= 1'b0;
            vec_num <= 3'h0;
        end
        else if (!serve_en || !global_irq_en || pick == 3'h0 || vec_ack)
        begin
            wait_cnt <= 5'h00;
            vec_ack <= 1'b0;
            vec_num <= vec_num + 3'h1;
        end
        else if (wait_cnt < 5'(extra_wait) + 5'h03)
            wait_cnt <= wait_cnt + 5'h01;
        else
        begin
            vec_ack <= 1'b1;
            vec_num <= pick;
        end
    end
endmodule // tpif_cpu_model
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpif_params.svh"
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic global_irq_en = 1'b0;
    logic vec_ack;
    logic [2:0] vec_num;
    logic [6:1] irq_req;
    tpif_pkg::tpif_timer_evt_t timer_evt = '0;
    logic [15:0] pins = 16'h0000;
    logic wdt_tick = 1'b0;
    tpif_pkg::tpif_fuse_t fuses = 6'h11;
    logic wake_req;
    logic serve_en = 1'b0;
    logic [3:0] extra_wait = 4'h0;
    logic [31:0] rd;
    logic [7:0] exp_flags, en, m, c;
    logic [3:0] ev;
    logic g, e;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    tpif_core dut
    (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .global_irq_en(global_irq_en),
        .vec_ack(vec_ack), .vec_num(vec_num), .irq_req(irq_req), .timer_evt(timer_evt),
        .port_a_pin(pins[7:0]), .port_b_pin(pins[15:8]), .wdt_tick(wdt_tick), .fuses(fuses),
        .wake_req(wake_req)
    );
    tpif_cpu_model u_cpu
    (
        .clk(clk), .rst(rst), .serve_en(serve_en), .extra_wait(extra_wait),
        .global_irq_en(global_irq_en), .irq_req(irq_req), .vec_ack(vec_ack), .vec_num(vec_num)
    );
    // Compare and count
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // One AHB-Lite transfer; read data in rd
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        rd = hrdata;
        check(32'h0, {31'h0, hresp});
    endtask
    // Flag byte of timer events
    function automatic logic [7:0] tbits(input logic [3:0] x);
        return {1'b0, x[3], x[2], 2'b00, x[1], x[0], 1'b0};
    endfunction
    // Set masks, toggle a pin, read the pin-change flag
    task automatic pin_case(input int idx, input logic [7:0] gm, input logic exp,
        input logic [11:0] alt = 12'h400, input logic [5:0] fz = 6'h11);
        fuses <= fz;
        bus(1'b1, `TPIF_OFS_ALT_CTRL, {20'h0, alt});
        bus(1'b1, `TPIF_OFS_GEN_MASK, {24'h0, gm});
        bus(1'b1, `TPIF_OFS_GEN_FLAGS, 32'h60);
        pins[idx] <= ~pins[idx];
        repeat (8) @(posedge clk);
        bus(1'b0, `TPIF_OFS_GEN_FLAGS, 32'h0);
        check({30'h0, exp, exp}, {30'h0, irq_req[2], rd[`TPIF_BIT_PC_FLAG]});
    endtask
    // Print counts and verdict
    task automatic summarize();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(55835));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        exp_flags = 8'h00;
        for (int a = 0; a < 8; a++)
        begin
            bus(1'b0, 12'(a * 4), 32'h0);
            check(32'h0, rd);
        end
        for (int i = 0; i < 24; i++)
        begin
            ev = 4'($urandom);
            en = 8'($urandom);
            g = 1'($urandom);
            bus(1'b1, `TPIF_OFS_TIMER_MASK, {24'h0, en});
            global_irq_en <= g;
            timer_evt <= ev;
            @(posedge clk);
            timer_evt <= 4'h0;
            exp_flags = exp_flags | tbits(ev);
            m = exp_flags & en & {8{g}};
            @(negedge clk);
            check({28'h0, m[1], m[2], m[5], m[6]}, {28'h0, irq_req[6:3]});
            @(posedge clk);
            bus(1'b0, `TPIF_OFS_TIMER_FLAGS, 32'h0);
            check({24'h0, exp_flags}, rd);
            c = 8'($urandom);
            bus(1'b1, `TPIF_OFS_TIMER_FLAGS, {24'($urandom), c});
            exp_flags = exp_flags & ~c;
            repeat (2) @(posedge clk);
        end
        bus(1'b1, `TPIF_OFS_TIMER_MASK, 32'h66);
        global_irq_en <= 1'b1;
        timer_evt <= 4'hf;
        @(posedge clk);
        timer_evt <= 4'h0;
        bus(1'b1, `TPIF_OFS_TIMER_FLAGS, 32'h42);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(32'h6, {28'h0, irq_req[6:3]});
        @(posedge clk);
        extra_wait <= 4'($urandom);
        serve_en <= 1'b1;
        for (int k = 0; k < 300 && irq_req[6:3] !== 4'h0; k++)
            @(posedge clk);
        serve_en <= 1'b0;
        bus(1'b0, `TPIF_OFS_TIMER_FLAGS, 32'h0);
        check(32'h0, rd);
        pin_case(3, 8'h30, 1'b1);
        pin_case(6, 8'h30, 1'b1);
        pin_case(7, 8'h30, 1'b1);
        pin_case(8, 8'h30, 1'b1);
        pin_case(11, 8'h10, 1'b1);
        pin_case(15, 8'h20, 1'b1);
        pin_case(10, 8'h20, 1'b0);
        pin_case(12, 8'h10, 1'b0);
        pin_case(3, 8'h30, 1'b0, 12'hc00);
        pin_case(6, 8'h30, 1'b0, 12'h000);
        pin_case(8, 8'h30, 1'b0, 12'h600);
        pin_case(8, 8'h30, 1'b0, 12'h448);
        pin_case(15, 8'h30, 1'b0, 12'h400, 6'h31);
        pin_case(12, 8'h30, 1'b0, 12'h400, 6'h10);
        bus(1'b1, `TPIF_OFS_GEN_MASK, 32'h60);
        for (int k = 2; k < 8; k++)
        begin
            e = (k / 2 == 1) || (k / 2 == 2 && k % 2 == 0) || (k / 2 == 3 && k % 2 == 1);
            bus(1'b1, `TPIF_OFS_MCU_CTRL, 32'(k / 2));
            pins[14] <= ~1'(k % 2);
            repeat (8) @(posedge clk);
            bus(1'b1, `TPIF_OFS_GEN_FLAGS, 32'h60);
            pins[14] <= 1'(k % 2);
            repeat (8) @(posedge clk);
            bus(1'b0, `TPIF_OFS_GEN_FLAGS, 32'h0);
            check({24'h0, 1'b0, e, 1'b1, 5'h0}, rd);
        end
        bus(1'b1, `TPIF_OFS_MCU_CTRL, 32'h0);
        pins[14] <= 1'b0;
        repeat (8) @(posedge clk);
        bus(1'b0, `TPIF_OFS_GEN_FLAGS, 32'h0);
        check(32'h0, rd & 32'h40);
        @(negedge clk);
        check(32'h1, {31'h0, irq_req[1]});
        for (int t = 0; t < 2; t++)
        begin
            @(posedge clk);
            wdt_tick <= 1'b1;
            @(posedge clk);
            wdt_tick <= 1'b0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            check({31'h0, t == 1}, {31'h0, wake_req});
        end
        @(posedge clk);
        pins[14] <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(32'h0, {31'h0, irq_req[1]});
        summarize();
    end
endmodule // testbench
`default_nettype wire
